// ---- logic/bank_map_pkg.sv ----
/*
  Constants for the upper-bank data memory decoder: address widths, bank
  geometry, region offsets and the waveform-generator register locations.
  Assumes a 12-bit flat data address; bank = addr[11:7], offset = addr[6:0].
*/
package bank_map_pkg;
  localparam int          ADDR_W       = 12;
  localparam int          OFS_W        = 7;
  localparam int          BANK_W       = 5;
  localparam int          DATA_W       = 8;
  localparam logic [11:0] FLAT_FIRST   = 12'h000;
  localparam logic [11:0] FLAT_LAST    = 12'hfff;
  localparam logic [4:0]  BANK_LO      = 5'h08;
  localparam logic [4:0]  BANK_HI      = 5'h0f;
  localparam logic [4:0]  BANK_RAM_END = 5'h0b;
  localparam logic [4:0]  BANK_SHORT   = 5'h0c;
  localparam logic [4:0]  BANK_WAVE    = 5'h0d;
  localparam logic [6:0]  OFS_CORE_END = 7'h0b;
  localparam logic [6:0]  OFS_RAM_LO   = 7'h20;
  localparam logic [6:0]  OFS_RAM_HI   = 7'h6f;
  localparam logic [6:0]  OFS_SHORT_HI = 7'h3f;
  localparam logic [6:0]  OFS_COMMON   = 7'h70;
  localparam logic [6:0]  OFS_WAVE_LO  = 7'h11;
  localparam logic [6:0]  OFS_WAVE_HI  = 7'h15;
  localparam int          RAM_PER_BANK = 80;
  localparam int          RAM_SHORT    = 32;
  localparam int          RAM_WORDS    = 4 * RAM_PER_BANK + RAM_SHORT;
  localparam int          RAM_AW       = 9;
  localparam int          COMMON_WORDS = 16;
  localparam int          WAVE_REGS    = 5;
  localparam logic [7:0]  ZERO_BYTE    = 8'h00;

  typedef enum logic [2:0] {
    TGT_NONE, TGT_CORE, TGT_RAM, TGT_COMMON, TGT_WAVE
  } target_t;
endpackage

// ---- logic/bank_region_decode.sv ----
/*
  Combinational decoder: classifies a 12-bit flat address into a target and
  the index inside that target. Assumes only banks 8 to 15 are meaningful
  here; other banks decode as unimplemented.
*/
`timescale 1ns/100ps
module bank_region_decode (
  input  wire logic [11:0]                  addr,
  output bank_map_pkg::target_t             target,
  output logic [bank_map_pkg::RAM_AW-1:0]   ram_index,
  output logic [3:0]                        common_index,
  output logic [3:0]                        core_index,
  output logic [2:0]                        wave_index
);
  logic [4:0] bank;
  logic [6:0] ofs;
  logic [8:0] bank_base;
  logic [8:0] ofs_in_ram;

  assign bank = addr[11:7];
  assign ofs  = addr[6:0];

  always_comb begin
    target       = bank_map_pkg::TGT_NONE;
    ofs_in_ram   = 9'({2'b00, ofs} - {2'b00, bank_map_pkg::OFS_RAM_LO});
    bank_base    = 9'((bank - bank_map_pkg::BANK_LO) * bank_map_pkg::RAM_PER_BANK);
    ram_index    = 9'(bank_base + ofs_in_ram);
    common_index = ofs[3:0];
    core_index   = ofs[3:0];
    wave_index   = 3'(ofs - bank_map_pkg::OFS_WAVE_LO);
    if (bank >= bank_map_pkg::BANK_LO && bank <= bank_map_pkg::BANK_HI) begin
      if (ofs <= bank_map_pkg::OFS_CORE_END) begin
        target = bank_map_pkg::TGT_CORE;
      end else if (ofs >= bank_map_pkg::OFS_COMMON) begin
        target = bank_map_pkg::TGT_COMMON;
      end else if (ofs >= bank_map_pkg::OFS_RAM_LO && ofs <= bank_map_pkg::OFS_RAM_HI
                   && bank <= bank_map_pkg::BANK_RAM_END) begin
        target = bank_map_pkg::TGT_RAM;
      end else if (bank == bank_map_pkg::BANK_SHORT && ofs >= bank_map_pkg::OFS_RAM_LO
                   && ofs <= bank_map_pkg::OFS_SHORT_HI) begin
        target = bank_map_pkg::TGT_RAM;
      end else if (bank == bank_map_pkg::BANK_WAVE && ofs >= bank_map_pkg::OFS_WAVE_LO
                   && ofs <= bank_map_pkg::OFS_WAVE_HI) begin
        target = bank_map_pkg::TGT_WAVE;
      end
    end
  end
endmodule

// ---- logic/banked_data_memory_decoder.sv ----
/*
  Upper banked data memory (banks 8 to 15) with its flat 12-bit view.
  Holds the scratch RAM, the shared common bytes and the five waveform
  registers as storage; core registers are reached through a side port to
  the core. Assumes the core issues at most one access per cycle and takes
  read data one cycle after the request, or two cycles for core register reads.
*/
// Overview of operation
// - Flat indirect space spans 000h to FFFh
// - Flat address equals absolute banked location
// - First twelve bank offsets reach core registers
// - Banks 8-11 hold 80 scratch bytes
// - Bank 12 holds 32 bytes, rest empty
// - Banks 13-15 scratch region reads zero
// - Offsets 70h-7Fh alias common RAM
// - Bank 13 691h-695h select waveform registers
// - Unimplemented locations read as zero
`timescale 1ns/100ps
module banked_data_memory_decoder (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [11:0] indirect_address_pointer,
  input  wire logic        mem_rd,
  input  wire logic        mem_wr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic [7:0]  core_rdata,
  output logic [7:0]       mem_rdata,
  output logic             mem_rvalid,
  output logic             core_sel,
  output logic             core_wr,
  output logic [3:0]       core_index,
  output logic [7:0]       core_wdata,
  output logic [7:0]       wave_rise_deadband_count,
  output logic [7:0]       wave_fall_deadband_count,
  output logic [7:0]       wave_control_zero,
  output logic [7:0]       wave_control_one,
  output logic [7:0]       wave_control_two
);
  // ----------------------------------------
  // Decode
  // ----------------------------------------
  bank_map_pkg::target_t  tgt;
  logic [8:0]             ram_idx;
  logic [3:0]             com_idx;
  logic [3:0]             cor_idx;
  logic [2:0]             wav_idx;

  // Full 12-bit pointer decoded with no remapping
  bank_region_decode u_dec (
    .addr         (indirect_address_pointer),
    .target       (tgt),
    .ram_index    (ram_idx),
    .common_index (com_idx),
    .core_index   (cor_idx),
    .wave_index   (wav_idx)
  );

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  logic [7:0] ram_q    [bank_map_pkg::RAM_WORDS];
  logic [7:0] common_q [bank_map_pkg::COMMON_WORDS];
  logic [7:0] wave_q   [bank_map_pkg::WAVE_REGS];
  logic [7:0] wave_d   [bank_map_pkg::WAVE_REGS];

  // RAM and common arrays carry no reset: scratch RAM contents are undefined at power-up
  // Only a decoded target takes a write, so empty space keeps nothing
  always_ff @(posedge sys_clk) begin
    if (mem_wr && tgt == bank_map_pkg::TGT_RAM) begin
      ram_q[ram_idx] <= mem_wdata;
    end
    if (mem_wr && tgt == bank_map_pkg::TGT_COMMON) begin
      common_q[com_idx] <= mem_wdata;
    end
  end

  always_comb begin
    for (int i = 0; i < bank_map_pkg::WAVE_REGS; i++) begin
      wave_d[i] = wave_q[i];
      if (mem_wr && tgt == bank_map_pkg::TGT_WAVE && wav_idx == 3'(i)) begin
        wave_d[i] = mem_wdata;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < bank_map_pkg::WAVE_REGS; i++) begin
      if (reset) begin
        wave_q[i] <= bank_map_pkg::ZERO_BYTE;
      end else begin
        wave_q[i] <= wave_d[i];
      end
    end
  end

  assign wave_rise_deadband_count = wave_q[0];
  assign wave_fall_deadband_count = wave_q[1];
  assign wave_control_zero        = wave_q[2];
  assign wave_control_one         = wave_q[3];
  assign wave_control_two         = wave_q[4];

  // ----------------------------------------
  // Core register side port
  // ----------------------------------------
  logic       core_sel_q, core_sel_d;
  logic       core_wr_q, core_wr_d;
  logic [3:0] core_index_q, core_index_d;
  logic [7:0] core_wdata_q, core_wdata_d;

  always_comb begin
    core_sel_d   = (mem_rd || mem_wr) && tgt == bank_map_pkg::TGT_CORE;
    core_wr_d    = mem_wr && tgt == bank_map_pkg::TGT_CORE;
    core_index_d = cor_idx;
    core_wdata_d = mem_wdata;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      core_sel_q   <= 1'b0;
      core_wr_q    <= 1'b0;
      core_index_q <= 4'h0;
      core_wdata_q <= bank_map_pkg::ZERO_BYTE;
    end else begin
      core_sel_q   <= core_sel_d;
      core_wr_q    <= core_wr_d;
      core_index_q <= core_index_d;
      core_wdata_q <= core_wdata_d;
    end
  end

  assign core_sel   = core_sel_q;
  assign core_wr    = core_wr_q;
  assign core_index = core_index_q;
  assign core_wdata = core_wdata_q;

  // ----------------------------------------
  // Read return
  // ----------------------------------------
  // Core data arrives a cycle late, so core reads finish one cycle after others
  logic       rvalid_q, rvalid_d;
  logic [7:0] rdata_q, rdata_d;
  logic       core_rd_q, core_rd_d;

  always_comb begin
    rvalid_d  = 1'b0;
    rdata_d   = bank_map_pkg::ZERO_BYTE;
    core_rd_d = mem_rd && tgt == bank_map_pkg::TGT_CORE;
    if (core_rd_q) begin
      rvalid_d = 1'b1;
      rdata_d  = core_rdata;
    end else if (mem_rd && tgt != bank_map_pkg::TGT_CORE) begin
      rvalid_d = 1'b1;
      unique case (tgt)
        bank_map_pkg::TGT_RAM:    rdata_d = ram_q[ram_idx];
        bank_map_pkg::TGT_COMMON: rdata_d = common_q[com_idx];
        bank_map_pkg::TGT_WAVE:   rdata_d = wave_q[wav_idx];
        default:                  rdata_d = bank_map_pkg::ZERO_BYTE;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rvalid_q  <= 1'b0;
      rdata_q   <= bank_map_pkg::ZERO_BYTE;
      core_rd_q <= 1'b0;
    end else begin
      rvalid_q  <= rvalid_d;
      rdata_q   <= rdata_d;
      core_rd_q <= core_rd_d;
    end
  end

  assign mem_rdata  = rdata_q;
  assign mem_rvalid = rvalid_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_unimpl_read_zero: assert property (@(posedge sys_clk) disable iff (reset)
    mem_rd && tgt == bank_map_pkg::TGT_NONE && !core_rd_q |=> mem_rvalid && mem_rdata == 8'h00)
    else $error("unimplemented read not zero");
  chk_upper_gpr_zero: assert property (@(posedge sys_clk) disable iff (reset)
    mem_rd && !core_rd_q && indirect_address_pointer >= 12'h6a0 && indirect_address_pointer <= 12'h6ef
    |=> mem_rdata == 8'h00)
    else $error("bank 13 scratch region not zero");
  chk_short_bank_hole: assert property (@(posedge sys_clk) disable iff (reset)
    indirect_address_pointer >= 12'h640 && indirect_address_pointer <= 12'h66f
    |-> tgt == bank_map_pkg::TGT_NONE)
    else $error("bank 12 hole decoded as storage");
  chk_core_window: assert property (@(posedge sys_clk) disable iff (reset)
    indirect_address_pointer[11] == 1'b0 && indirect_address_pointer[10] == 1'b1
    && indirect_address_pointer[6:0] <= 7'h0b |-> tgt == bank_map_pkg::TGT_CORE)
    else $error("core offset not routed to core");
  chk_core_read_lat: assert property (@(posedge sys_clk) disable iff (reset)
    mem_rd && tgt == bank_map_pkg::TGT_CORE |=> core_sel ##1 (mem_rvalid && mem_rdata == $past(core_rdata)))
    else $error("core read return wrong");
  chk_wave_select: assert property (@(posedge sys_clk) disable iff (reset)
    mem_wr && indirect_address_pointer == 12'h691 |=> wave_rise_deadband_count == $past(mem_wdata))
    else $error("rise dead-band write lost");
  chk_common_alias: assert property (@(posedge sys_clk) disable iff (reset)
    mem_wr && indirect_address_pointer == 12'h47a ##1 !mem_wr ##1 mem_rd && indirect_address_pointer == 12'h7fa
    && !mem_wr && !core_rd_q |=> mem_rdata == $past(mem_wdata, 3))
    else $error("common window not shared");
  chk_ram_bank8: assert property (@(posedge sys_clk) disable iff (reset)
    indirect_address_pointer >= 12'h420 && indirect_address_pointer <= 12'h46f |-> tgt == bank_map_pkg::TGT_RAM)
    else $error("bank 8 scratch not decoded");
  chk_unimpl_write: assert property (@(posedge sys_clk) disable iff (reset)
    mem_wr && tgt == bank_map_pkg::TGT_NONE |=> $stable(wave_rise_deadband_count) && !core_wr)
    else $error("unimplemented write had effect");
  chk_bank12_ram: assert property (@(posedge sys_clk) disable iff (reset)
    indirect_address_pointer >= 12'h620 && indirect_address_pointer <= 12'h63f
    |-> tgt == bank_map_pkg::TGT_RAM)
    else $error("bank 12 scratch not decoded");
  chk_upper_region_empty: assert property (@(posedge sys_clk) disable iff (reset)
    indirect_address_pointer[11:7] >= 5'h0d && indirect_address_pointer[11:7] <= 5'h0f
    && indirect_address_pointer[6:0] >= 7'h20 && indirect_address_pointer[6:0] <= 7'h6f
    |-> tgt == bank_map_pkg::TGT_NONE)
    else $error("banks 13-15 scratch region decoded");
  chk_core_sel_gate: assert property (@(posedge sys_clk) disable iff (reset)
    (mem_rd || mem_wr) && tgt != bank_map_pkg::TGT_CORE |=> !core_sel && !core_wr)
    else $error("core port selected for non-core access");
endmodule

// ---- dv/core_reg_model.sv ----
/*
  Behavioural model of the twelve shared core registers behind the side port.
  Assumes core_index stays below 12 whenever core_sel is high.
*/
`timescale 1ns/100ps
module core_reg_model (
  input  wire logic       sys_clk,
  input  wire logic       core_sel,
  input  wire logic       core_wr,
  input  wire logic [3:0] core_index,
  input  wire logic [7:0] core_wdata,
  output logic [7:0]      core_rdata
);
  // --------------------------------
  // Storage and answer
  // --------------------------------
  logic [7:0] regs [12];
  logic [7:0] last_q;
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 12; i++) begin
      regs[i] = 8'hc0 + 8'(i);
    end
  end
  // Unselected data is inverted so a stale byte cannot pass as an answer
  always_comb core_rdata = core_sel ? regs[core_index] : ~last_q;
  always @(posedge sys_clk) begin
    if (core_sel && core_wr) begin
      regs[core_index] <= core_wdata;
    end
    if (core_sel) begin
      last_q <= regs[core_index];
    end
  end
endmodule

// ---- dv/banked_data_memory_decoder_bench.sv ----
/*
  Self-checking bench for the upper-bank decoder and the core register model.
  Assumes one idle cycle between accesses is always legal.
*/
`timescale 1ns/100ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin errors++; $display("BAD %0t got %h want %h", $time, a, e); end end
module banked_data_memory_decoder_bench;
  logic        sys_clk, reset, mem_rd, mem_wr, mem_rvalid, core_sel, core_wr;
  logic [11:0] indirect_address_pointer;
  logic [7:0]  mem_wdata, core_rdata, mem_rdata, core_wdata;
  logic [3:0]  core_index;
  logic [7:0]  wave_rise_deadband_count, wave_fall_deadband_count;
  logic [7:0]  wave_control_zero, wave_control_one, wave_control_two;
  int          errors, num_checks;
  banked_data_memory_decoder dut (.sys_clk, .reset, .indirect_address_pointer, .mem_rd, .mem_wr,
    .mem_wdata, .core_rdata, .mem_rdata, .mem_rvalid, .core_sel, .core_wr, .core_index, .core_wdata,
    .wave_rise_deadband_count, .wave_fall_deadband_count, .wave_control_zero, .wave_control_one,
    .wave_control_two);
  core_reg_model far_end (.sys_clk, .core_sel, .core_wr, .core_index, .core_wdata, .core_rdata);
  // --------------------------------
  // Access tasks
  // --------------------------------
  // Each access starts on a fresh edge, which leaves the idle cycle after core reads
  task automatic wr_b(input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    #1 indirect_address_pointer = a;
    mem_wdata = d;
    mem_wr = 1'b1;
    @(posedge sys_clk);
    #1 mem_wr = 1'b0;
  endtask
  task automatic rd_b(input logic [11:0] a, input logic [7:0] e, input logic c);
    @(posedge sys_clk);
    #1 indirect_address_pointer = a;
    mem_rd = 1'b1;
    @(posedge sys_clk);
    #1 mem_rd = 1'b0;
    `CHK(core_sel, c)
    if (c) `CHK(core_index, a[3:0])
    if (c) `CHK(core_wr, 1'b0)
    for (int i = 0; i < 3 && mem_rvalid !== 1'b1; i++) begin
      @(posedge sys_clk);
      #1;
    end
    `CHK(mem_rvalid, 1'b1)
    `CHK(mem_rdata, e)
  endtask
  // --------------------------------
  // Scenarios
  // --------------------------------
  task automatic t_ram;
    for (int b = 0; b < 4; b++) begin
      wr_b(12'h420 + 12'(b * 128), 8'h10 + 8'(b));
      wr_b(12'h46f + 12'(b * 128), 8'h20 + 8'(b));
    end
    wr_b(12'h620, 8'h33);
    wr_b(12'h63f, 8'h44);
    for (int b = 0; b < 4; b++) begin
      rd_b(12'h420 + 12'(b * 128), 8'h10 + 8'(b), 1'b0);
      rd_b(12'h46f + 12'(b * 128), 8'h20 + 8'(b), 1'b0);
    end
    rd_b(12'h620, 8'h33, 1'b0);
    rd_b(12'h63f, 8'h44, 1'b0);
  endtask
  task automatic t_wave;
    for (int i = 0; i < 5; i++) begin
      wr_b(12'h691 + 12'(i), 8'h61 + 8'(i));
    end
    `CHK(wave_rise_deadband_count, 8'h61)
    `CHK(wave_fall_deadband_count, 8'h62)
    `CHK(wave_control_zero, 8'h63)
    `CHK(wave_control_one, 8'h64)
    `CHK(wave_control_two, 8'h65)
  endtask
  task automatic t_empty;
    logic [11:0] z [10] = '{12'h640, 12'h66f, 12'h6a0, 12'h6ef, 12'h76f, 12'h7a0, 12'h40c, 12'h41f,
                            12'h696, 12'h690};
    foreach (z[i]) wr_b(z[i], 8'hff);
    foreach (z[i]) rd_b(z[i], 8'h00, 1'b0);
    `CHK(wave_control_two, 8'h65)
    rd_b(12'h420, 8'h10, 1'b0);
    rd_b(12'h63f, 8'h44, 1'b0);
  endtask
  task automatic t_common;
    wr_b(12'h470, 8'h5a);
    wr_b(12'h7ff, 8'ha5);
    for (int b = 0; b < 8; b++) begin
      rd_b(12'h470 + 12'(b * 128), 8'h5a, 1'b0);
      rd_b(12'h47f + 12'(b * 128), 8'ha5, 1'b0);
    end
    wr_b(12'h47a, 8'h3c);
    rd_b(12'h7fa, 8'h3c, 1'b0);
  endtask
  task automatic t_core;
    rd_b(12'h403, 8'hc3, 1'b1);
    rd_b(12'h700, 8'hc0, 1'b1);
    wr_b(12'h78b, 8'h9e);
    `CHK(core_sel, 1'b1)
    `CHK(core_wr, 1'b1)
    `CHK(core_index, 4'hb)
    `CHK(core_wdata, 8'h9e)
    rd_b(12'h40b, 8'h9e, 1'b1);
  endtask
  task automatic t_reset;
    @(posedge sys_clk);
    #1 reset = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1 reset = 1'b0;
    `CHK(wave_rise_deadband_count, 8'h00)
    `CHK(wave_control_two, 8'h00)
    `CHK(mem_rvalid, 1'b0)
    `CHK(core_sel, 1'b0)
  endtask
  task automatic summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // --------------------------------
  // Clock, reset, sequence
  // --------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  initial begin
    errors = 0;
    num_checks = 0;
    reset = 1'b1;
    mem_rd = 1'b0;
    mem_wr = 1'b0;
    mem_wdata = 8'h00;
    indirect_address_pointer = 12'h000;
    repeat (16) @(posedge sys_clk);
    #1 reset = 1'b0;
    `CHK(mem_rvalid, 1'b0)
    `CHK(wave_control_one, 8'h00)
    t_ram;
    t_wave;
    t_empty;
    t_common;
    t_core;
    t_reset;
    rd_b(12'h000, 8'h00, 1'b0);
    rd_b(12'hfff, 8'h00, 1'b0);
    summarize;
  end
  // Whole sequence needs about 170 cycles; allow far more
  initial begin
    #200000;
    errors++;
    summarize;
  end
endmodule
